// >>> hw/uart_checksum_collision_monitor.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
module uart_checksum_collision_monitor
  import chk_col_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // From the UART core, same clock
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_fifo_full,
  input wire logic dali_midbit_missing,
  input wire logic lin_checksum_error,
  // To the UART core
  output logic tx_ready,
  output logic transmitter_enable,
  output logic receiver_enable,
  output logic [1:0] uart_mode,
  output logic run_on_overflow,
  output logic rx_flush,
  output logic collision_irq
);
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    uart_mode_e mode;
    logic checksum_enable;
    logic run_on_overflow;
    logic rx_flush;
    logic [7:0] tx_checksum_reg;
    logic [7:0] rx_checksum_reg;
    logic tx_collision_flag;
    logic rx_overflow_flag;
    logic checksum_error_flag;
    logic tx_collision_irq_enable;
    logic rx_overflow_irq_enable;
    logic checksum_error_irq_enable;
    logic collision_irq;
    logic tx_ready;
    logic [7:0] rdata;
  } mon_s;

  mon_s st;
  mon_s next_st;

  logic both_en;
  logic sum_active;
  logic tx_push;
  logic echo_valid;
  logic [7:0] echo_data;
  logic echo_ready;
  logic buf_in_ready;
  logic mismatch;
  logic [7:0] error_flags;
  logic [7:0] error_enables;

  ////////////////////////////////////////////////////////////////////////////////
  // End-around carry add: the carry out re-enters at bit 0
  function automatic logic [7:0] fold_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Echo tracking
  assign both_en = st.tx_en && st.rx_en;
  assign tx_push = tx_byte_valid && both_en;
  // Echoes drain on every received byte; with detection off the buffer just empties
  assign echo_ready = rx_byte_valid || !both_en;

  echo_buffer u_echo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(tx_push),
    .in_data(tx_byte),
    .in_ready(buf_in_ready),
    .out_valid(echo_valid),
    .out_data(echo_data),
    .out_ready(echo_ready)
  );

  // In 7-bit mode the top bit carries no data and is not compared
  always_comb begin
    if (st.mode == MODE_ASYNC7) begin
      mismatch = (echo_data[6:0] & LOW7_MASK) != (rx_byte[6:0] & LOW7_MASK);
    end else begin
      mismatch = echo_data != rx_byte;
    end
  end

  assign sum_active = st.checksum_enable && (st.mode != MODE_LIN);

  always_comb begin
    error_flags = RESET_BYTE;
    error_flags[BIT_TX_COLLISION] = st.tx_collision_flag;
    error_flags[BIT_RX_OVERFLOW] = st.rx_overflow_flag;
    error_flags[BIT_CHECKSUM_ERROR] = st.checksum_error_flag;
    error_enables = RESET_BYTE;
    error_enables[BIT_TX_COLLISION] = st.tx_collision_irq_enable;
    error_enables[BIT_RX_OVERFLOW] = st.rx_overflow_irq_enable;
    error_enables[BIT_CHECKSUM_ERROR] = st.checksum_error_irq_enable;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rx_flush = 1'b0;
    next_st.rdata = RESET_BYTE;

    // Accumulate before the software write so a write in the same cycle wins
    if (sum_active && tx_byte_valid) begin
      next_st.tx_checksum_reg = fold_add(st.tx_checksum_reg, tx_byte);
    end
    if (sum_active && rx_byte_valid) begin
      next_st.rx_checksum_reg = fold_add(st.rx_checksum_reg, rx_byte);
    end

    // Register writes; flags are write-one-to-clear
    if (reg_we) begin
      unique case (reg_addr)
        ADDR_CONTROL_ZERO: begin
          next_st.tx_en = reg_wdata[BIT_TRANSMITTER_ENABLE];
          next_st.rx_en = reg_wdata[BIT_RECEIVER_ENABLE];
          next_st.mode = uart_mode_e'(reg_wdata[POS_MODE+:2]);
        end
        ADDR_UART_CONTROL_TWO: begin
          next_st.checksum_enable = reg_wdata[BIT_CHECKSUM_ENABLE];
          next_st.run_on_overflow = reg_wdata[BIT_RUN_ON_OVERFLOW];
          next_st.rx_flush = reg_wdata[BIT_RX_FLUSH];
        end
        ADDR_TX_CHECKSUM: begin
          next_st.tx_checksum_reg = reg_wdata;
        end
        ADDR_RX_CHECKSUM: begin
          next_st.rx_checksum_reg = reg_wdata;
        end
        ADDR_ERROR_FLAG: begin
          if (reg_wdata[BIT_TX_COLLISION]) next_st.tx_collision_flag = 1'b0;
          if (reg_wdata[BIT_RX_OVERFLOW]) next_st.rx_overflow_flag = 1'b0;
          if (reg_wdata[BIT_CHECKSUM_ERROR]) next_st.checksum_error_flag = 1'b0;
        end
        ADDR_ERROR_ENABLE: begin
          next_st.tx_collision_irq_enable = reg_wdata[BIT_TX_COLLISION];
          next_st.rx_overflow_irq_enable = reg_wdata[BIT_RX_OVERFLOW];
          next_st.checksum_error_irq_enable = reg_wdata[BIT_CHECKSUM_ERROR];
        end
        default: begin
        end
      endcase
    end

    // Hardware sets come after the clear so that a set wins
    if (rx_byte_valid && both_en && echo_valid && mismatch) begin
      next_st.tx_collision_flag = 1'b1;
    end
    if (dali_midbit_missing && both_en && st.mode == MODE_DALI) begin
      next_st.tx_collision_flag = 1'b1;
    end
    // Overflow is only flagged; the UART decides to keep or drop by run_on_overflow
    if (rx_byte_valid && rx_fifo_full) begin
      next_st.rx_overflow_flag = 1'b1;
    end
    if (lin_checksum_error && st.mode == MODE_LIN) begin
      next_st.checksum_error_flag = 1'b1;
    end

    next_st.collision_irq = next_st.tx_collision_flag && next_st.tx_collision_irq_enable;
    next_st.tx_ready = buf_in_ready;

    // Read data stands the cycle after the strobe; unmapped reads return zero
    if (reg_re) begin
      unique case (reg_addr)
        ADDR_CONTROL_ZERO: begin
          next_st.rdata[BIT_TRANSMITTER_ENABLE] = st.tx_en;
          next_st.rdata[BIT_RECEIVER_ENABLE] = st.rx_en;
          next_st.rdata[POS_MODE+:2] = st.mode;
        end
        ADDR_UART_CONTROL_TWO: begin
          next_st.rdata[BIT_CHECKSUM_ENABLE] = st.checksum_enable;
          next_st.rdata[BIT_RUN_ON_OVERFLOW] = st.run_on_overflow;
        end
        ADDR_TX_CHECKSUM: next_st.rdata = st.tx_checksum_reg;
        ADDR_RX_CHECKSUM: next_st.rdata = st.rx_checksum_reg;
        ADDR_ERROR_FLAG: next_st.rdata = error_flags;
        ADDR_ERROR_ENABLE: next_st.rdata = error_enables;
        default: next_st.rdata = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata = st.rdata;
  // Registered copy lags the buffer by a cycle, so a stall may come one word late
  assign tx_ready = st.tx_ready;
  assign transmitter_enable = st.tx_en;
  assign receiver_enable = st.rx_en;
  assign uart_mode = st.mode;
  assign run_on_overflow = st.run_on_overflow;
  assign rx_flush = st.rx_flush;
  assign collision_irq = st.collision_irq;
endmodule // uart_checksum_collision_monitor

// >>> hw/chk_col_pkg.sv
package chk_col_pkg;
  // Register offsets
  localparam logic [3:0] ADDR_CONTROL_ZERO = 4'h0;
  localparam logic [3:0] ADDR_UART_CONTROL_TWO = 4'h1;
  localparam logic [3:0] ADDR_TX_CHECKSUM = 4'h2;
  localparam logic [3:0] ADDR_RX_CHECKSUM = 4'h3;
  localparam logic [3:0] ADDR_ERROR_FLAG = 4'h4;
  localparam logic [3:0] ADDR_ERROR_ENABLE = 4'h5;
  // control_zero fields
  localparam int BIT_TRANSMITTER_ENABLE = 0;
  localparam int BIT_RECEIVER_ENABLE = 1;
  localparam int POS_MODE = 2;
  // uart_control_two fields
  localparam int BIT_CHECKSUM_ENABLE = 0;
  localparam int BIT_RX_FLUSH = 6;
  localparam int BIT_RUN_ON_OVERFLOW = 7;
  // error_flag_reg and error enable fields
  localparam int BIT_TX_COLLISION = 0;
  localparam int BIT_RX_OVERFLOW = 1;
  localparam int BIT_CHECKSUM_ERROR = 4;
  // Reset value and 7-bit compare mask
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] LOW7_MASK = 7'h7F;
  typedef enum logic [1:0] {
    MODE_ASYNC8,
    MODE_ASYNC7,
    MODE_LIN,
    MODE_DALI
  } uart_mode_e;
endpackage

// >>> hw/echo_buffer.sv
`timescale 1ns/10ps
// Two-entry buffer holding transmitted words until their echo arrives
module echo_buffer
  import chk_col_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Filling side
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } buf_s;

  buf_s st;
  buf_s next_st;
  logic push;
  logic pop;

  assign in_ready = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data = st.mem[st.rp];

  always_comb begin
    next_st = st;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = ~st.wp;
    end
    if (pop) begin
      next_st.rp = ~st.rp;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 2'h1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule // echo_buffer

// >>> tb/loop_node.sv
`timescale 1ns/10ps
// Far node on a looped line: echoes every sent byte, may hold or corrupt it
module loop_node (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Line from the UART
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  // Test controls
  input wire logic hold,
  input wire logic [7:0] flip,
  // Echo back
  output logic rx_byte_valid,
  output logic [7:0] rx_byte
);
  logic [7:0] q[$];
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q.delete();
      rx_byte_valid <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      if (tx_byte_valid) q.push_back(tx_byte);
      rx_byte_valid <= 1'b0;
      // Idle line never repeats the last word
      rx_byte <= ~rx_byte;
      if (!hold && q.size() > 0) begin
        rx_byte_valid <= 1'b1;
        rx_byte <= q.pop_front() ^ flip;
      end
    end
  end
endmodule // loop_node

// >>> tb/chk_col_assertions.sv
`timescale 1ns/10ps
module chk_col_checker
  import chk_col_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_byte_valid,
  input wire logic dali_midbit_missing,
  input wire logic transmitter_enable,
  input wire logic receiver_enable,
  input wire logic [1:0] uart_mode,
  input wire logic run_on_overflow,
  input wire logic rx_flush,
  input wire logic collision_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic col_en;
  wire w_ctl0 = reg_we && reg_addr == ADDR_CONTROL_ZERO;
  wire w_ctl2 = reg_we && reg_addr == ADDR_UART_CONTROL_TWO;
  wire w_ien = reg_we && reg_addr == ADDR_ERROR_ENABLE;
  wire w_flg = reg_we && reg_addr == ADDR_ERROR_FLAG;
  // Shadow of the collision enable, so the request can be judged from the ports
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      col_en <= 1'b0;
    else if (w_ien)
      col_en <= reg_wdata[BIT_TX_COLLISION];
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_flush_req;
    w_ctl2 && reg_wdata[BIT_RX_FLUSH];
  endsequence
  sequence s_dali_hit;
    dali_midbit_missing && uart_mode == MODE_DALI && transmitter_enable && receiver_enable;
  endsequence
  property p_flush; s_flush_req |=> rx_flush; endproperty
  property p_rdata_idle; !$past(reg_re) |-> reg_rdata == 8'h00; endproperty
  property p_run_on_overflow; w_ctl2 |=> run_on_overflow == $past(reg_wdata[BIT_RUN_ON_OVERFLOW]); endproperty
  property p_enables;
    w_ctl0 |=> {receiver_enable, transmitter_enable} == $past(reg_wdata[1:0]) && uart_mode == $past(reg_wdata[3:2]);
  endproperty
  property p_irq_off; !col_en && !$past(col_en) |-> !collision_irq; endproperty
  property p_irq_cause;
    $rose(collision_irq) |-> $past(rx_byte_valid || dali_midbit_missing || w_ien) || $past(w_ien, 2);
  endproperty
  property p_dali; s_dali_hit and col_en && !w_ien |=> collision_irq; endproperty
  property p_irq_hold; collision_irq && col_en && !w_ien && !w_flg |=> collision_irq; endproperty
  a_flush: assert property (p_flush) else $error("flush pulse missing");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_run_on_overflow: assert property (p_run_on_overflow) else $error("overflow run bit wrong");
  a_enables: assert property (p_enables) else $error("enables or mode wrong");
  a_irq_off: assert property (p_irq_off) else $error("request while disabled");
  a_irq_cause: assert property (p_irq_cause) else $error("request without cause");
  a_dali: assert property (p_dali) else $error("mid-bit miss not flagged");
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped early");
endmodule // chk_col_checker

bind uart_checksum_collision_monitor chk_col_checker u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .rx_byte_valid(rx_byte_valid),
  .dali_midbit_missing(dali_midbit_missing), .transmitter_enable(transmitter_enable),
  .receiver_enable(receiver_enable), .uart_mode(uart_mode), .run_on_overflow(run_on_overflow),
  .rx_flush(rx_flush), .collision_irq(collision_irq));

// >>> tb/uart_checksum_collision_monitor_tb.sv
`timescale 1ns/10ps
module uart_checksum_collision_monitor_tb;
  import chk_col_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, reg_we = 1'b0, reg_re = 1'b0, tx_byte_valid = 1'b0, rx_fifo_full = 1'b0;
  logic hold = 1'b0, rx_byte_valid, tx_ready, transmitter_enable, receiver_enable, run_on_overflow, rx_flush;
  logic collision_irq;
  logic [1:0] ev = 2'b00, uart_mode;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, tx_byte = 8'h00, flip = 8'h00, reg_rdata, rx_byte;
  int err_total = 0, checked = 0;
  uart_checksum_collision_monitor dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_fifo_full(rx_fifo_full), .dali_midbit_missing(ev[1]),
    .lin_checksum_error(ev[0]), .tx_ready(tx_ready), .transmitter_enable(transmitter_enable),
    .receiver_enable(receiver_enable), .uart_mode(uart_mode), .run_on_overflow(run_on_overflow),
    .rx_flush(rx_flush), .collision_irq(collision_irq));
  loop_node node (.clk(clk), .nrst(nrst), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte), .hold(hold),
    .flip(flip), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));
  initial begin
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, exp);
  endtask
  // Waits for room, then sends one byte and lets its echo land
  // Room is judged on settled values; the byte itself is launched on a rising edge
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    #1;
    while (tx_ready !== 1'b1) begin
      @(posedge clk);
      #1 n++;
      if (n > 50) begin
        err_total++;
        end_sim();
      end
    end
    @(posedge clk);
    tx_byte_valid <= 1'b1;
    tx_byte <= b;
    @(posedge clk);
    tx_byte_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [1:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 2'b00;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    for (int a = 0; a < 8; a++) rd(4'(a), 8'h00);
    wr(ADDR_CONTROL_ZERO, 8'h03);
    wr(ADDR_ERROR_ENABLE, 8'h01);
    wr(ADDR_TX_CHECKSUM, 8'h00);
    wr(ADDR_RX_CHECKSUM, 8'h00);
    wr(ADDR_UART_CONTROL_TWO, 8'h01);
    send(8'hF0);
    send(8'h20);
    rd(ADDR_TX_CHECKSUM, 8'h11);
    rd(ADDR_RX_CHECKSUM, 8'h11);
    send(8'hEE);
    rd(ADDR_RX_CHECKSUM, 8'hFF);
    rd(ADDR_ERROR_FLAG, 8'h00);
    flip <= 8'h01;
    send(8'h5A);
    flip <= 8'h00;
    chk("collision_irq", collision_irq, 8'h01);
    rd(ADDR_ERROR_FLAG, 8'h01);
    wr(ADDR_ERROR_FLAG, 8'h01);
    wr(ADDR_ERROR_ENABLE, 8'h00);
    flip <= 8'h01;
    send(8'h5A);
    flip <= 8'h00;
    chk("collision_irq", collision_irq, 8'h00);
    rd(ADDR_ERROR_FLAG, 8'h01);
    wr(ADDR_ERROR_FLAG, 8'h01);
    wr(ADDR_TX_CHECKSUM, 8'h00);
    wr(ADDR_UART_CONTROL_TWO, 8'h00);
    send(8'h33);
    rd(ADDR_TX_CHECKSUM, 8'h00);
    wr(ADDR_UART_CONTROL_TWO, 8'h01);
    wr(ADDR_CONTROL_ZERO, 8'h0B);
    send(8'h33);
    rd(ADDR_TX_CHECKSUM, 8'h00);
    pulse(2'b01);
    rd(ADDR_ERROR_FLAG, 8'h10);
    wr(ADDR_ERROR_FLAG, 8'h10);
    wr(ADDR_CONTROL_ZERO, 8'h03);
    pulse(2'b01);
    rd(ADDR_ERROR_FLAG, 8'h00);
    wr(ADDR_ERROR_ENABLE, 8'h01);
    wr(ADDR_CONTROL_ZERO, 8'h0F);
    #1 chk("enables", {4'h0, uart_mode, receiver_enable, transmitter_enable}, 8'h0F);
    pulse(2'b10);
    rd(ADDR_ERROR_FLAG, 8'h01);
    wr(ADDR_ERROR_FLAG, 8'h01);
    wr(ADDR_CONTROL_ZERO, 8'h03);
    hold <= 1'b1;
    send(8'h01);
    send(8'h02);
    chk("tx_ready", tx_ready, 8'h00);
    hold <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("tx_ready", tx_ready, 8'h01);
    rd(ADDR_ERROR_FLAG, 8'h00);
    wr(ADDR_UART_CONTROL_TWO, 8'h81);
    rx_fifo_full <= 1'b1;
    #1 chk("run_on_overflow", run_on_overflow, 8'h01);
    rd(ADDR_UART_CONTROL_TWO, 8'h81);
    send(8'h44);
    rx_fifo_full <= 1'b0;
    rd(ADDR_ERROR_FLAG, 8'h02);
    wr(ADDR_UART_CONTROL_TWO, 8'h40);
    #1 chk("rx_flush", rx_flush, 8'h01);
    wr(ADDR_ERROR_FLAG, 8'h02);
    wr(ADDR_CONTROL_ZERO, 8'h07);
    flip <= 8'h80;
    send(8'h15);
    flip <= 8'h00;
    rd(ADDR_ERROR_FLAG, 8'h00);
    end_sim();
  end
endmodule // uart_checksum_collision_monitor_tb
